// >>> rtl/mhc_defines.vh
// register offsets, field positions, reset values and timing counts
// assumes inclusion by the heater control files only
`ifndef MHC_DEFINES_VH
`define MHC_DEFINES_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define MHC_OFS_CTRL    8'h00
`define MHC_OFS_LEVEL   8'h04
`define MHC_OFS_TOPO    8'h08
`define MHC_OFS_DICFG   8'h0C
`define MHC_OFS_PHASE   8'h10
`define MHC_OFS_PF      8'h14
`define MHC_OFS_STATUS  8'h18

// ----------------------------------------------------------------
// field positions and widths
// ----------------------------------------------------------------
`define MHC_CTRL_HDIS   0
`define MHC_CTRL_START  1
`define MHC_CTRL_STOP   2
`define MHC_LEVEL_W     5
`define MHC_TOPO_W      3
`define MHC_DICFG_W     6
`define MHC_PF_W        8

// ----------------------------------------------------------------
// encodings
// ----------------------------------------------------------------
`define MHC_LEVEL_OFF   5'h00
`define MHC_LEVEL_MAX   5'h19
`define MHC_TOPO_NORMAL 3'h0
`define MHC_TOPO_INDELT 3'h1
`define MHC_TOPO_WYEDEL 3'h2
`define MHC_TOPO_PHASE  3'h3
`define MHC_TOPO_CURFOL 3'h4
`define MHC_TOPO_DIRECT 3'h5
`define MHC_DI_NONE     2'h0
`define MHC_DI_HEAT_EN  2'h1
`define MHC_DI_HEAT_DIS 2'h2
`define MHC_PH_INSENS   2'h0
`define MHC_PH_SINGLE   2'h3
`define MHC_PF_MIN      8'h9C
`define MHC_PF_MAX      8'h64
`define MHC_PF_RESET    8'hA4

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define MHC_CLK_NS      40
`define MHC_HEAT_OFF_NS 1000
`define MHC_HEAT_OFF_CYC ((`MHC_HEAT_OFF_NS + `MHC_CLK_NS - 1) / `MHC_CLK_NS)

`endif

// >>> rtl/mhc_sync3.v
// three-stage input synchroniser with agreement filter
// assumes din is asynchronous to pclk
`timescale 1ns/100ps
module mhc_sync3 #(
  parameter W = 3
) (
  input  wire         pclk,
  input  wire         presetn,
  input  wire         ce,
  input  wire [W-1:0] din,
  output reg  [W-1:0] dout
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;
  integer i;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= {W{1'b0}};
      s2_q <= {W{1'b0}};
      s3_q <= {W{1'b0}};
      dout <= {W{1'b0}};
    end else if (ce) begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (i = 0; i < W; i = i + 1) begin
        if (s2_q[i] == s3_q[i]) begin
          dout[i] <= s3_q[i];
        end
      end
    end
  end
endmodule // mhc_sync3

// >>> rtl/mhc_start_seq.v
// start sequencer: clears heating, waits, then starts the motor
// assumes start and stop are one-cycle pulses on pclk
`timescale 1ns/100ps
`include "mhc_defines.vh"
module mhc_start_seq #(
  parameter GAP_CYC = `MHC_HEAT_OFF_CYC
) (
  input  wire       pclk,
  input  wire       presetn,
  input  wire       ce,
  input  wire       start,
  input  wire       stop,
  output wire       stopped,
  output reg        run_q,
  output reg        go_q,
  output wire [1:0] state
);
  localparam [1:0] S_IDLE = 2'b00;
  localparam [1:0] S_GAP  = 2'b01;
  localparam [1:0] S_RUN  = 2'b10;
  localparam [7:0] GAP8   = GAP_CYC[7:0];

  reg [1:0] st_q;
  reg [1:0] st_d;
  reg [7:0] cnt_q;

  assign stopped = (st_q == S_IDLE);
  assign state   = st_q;

  always @* begin
    st_d = st_q;
    case (st_q)
      S_IDLE:  if (start && !stop) st_d = S_GAP;
      S_GAP:   if (stop) st_d = S_IDLE;
               else if (cnt_q == 8'h01) st_d = S_RUN;
      S_RUN:   if (stop) st_d = S_IDLE;
      default: st_d = S_IDLE;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q  <= S_IDLE;
      cnt_q <= 8'h00;
      run_q <= 1'b0;
      go_q  <= 1'b0;
    end else if (ce) begin
      st_q  <= st_d;
      run_q <= (st_d == S_RUN);
      go_q  <= (st_q == S_GAP) && (st_d == S_RUN);
      if (st_q == S_IDLE) begin
        cnt_q <= GAP8;
      end else if (cnt_q != 8'h00) begin
        cnt_q <= cnt_q - 8'h01;
      end
    end
  end
endmodule // mhc_start_seq

// >>> rtl/mhc_top.v
// motor winding heater / anti-windmilling enable control with apb registers
// assumes apb3 master on pclk; prog inputs are asynchronous pins
//
// Local design decisions: the register addresses and the APB register port.
`timescale 1ns/100ps
`include "mhc_defines.vh"
module mhc_top #(
  parameter GAP_CYC = `MHC_HEAT_OFF_CYC
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        ce,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        prog_input_one,
  input  wire        prog_input_two,
  input  wire        prog_input_three,
  output reg         dc_heat_en,
  output reg  [4:0]  dc_heat_level,
  output wire [2:0]  starter_topology,
  output wire [1:0]  phase_order,
  output wire [7:0]  rated_pf,
  output wire        motor_run,
  output wire        motor_start_pulse
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function lvl_ok;
    input [4:0] v;
    begin
      lvl_ok = (v <= `MHC_LEVEL_MAX);
    end
  endfunction

  function pf_ok;
    input [7:0] v;
    begin
      pf_ok = (v != 8'h00) &&
              ((!v[7] && v <= `MHC_PF_MAX) || (v[7] && v >= `MHC_PF_MIN));
    end
  endfunction

  function [2:0] di_has;
    input [5:0] cfg;
    input [1:0] code;
    begin
      di_has = {cfg[5:4] == code, cfg[3:2] == code, cfg[1:0] == code};
    end
  endfunction

  function topo_ok;
    input [2:0] v;
    begin
      topo_ok = (v <= `MHC_TOPO_DIRECT);
    end
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg        hdis_q;
  reg [4:0]  level_q;
  reg [2:0]  topo_q;
  reg [5:0]  dicfg_q;
  reg [1:0]  phase_q;
  reg [7:0]  pf_q;
  reg        start_q;
  reg        stop_q;
  wire [2:0] di_s;
  wire       stopped;
  wire       run;
  wire [1:0] seq_state;
  wire       go;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  mhc_sync3 #(
    .W (3)
  ) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .din     ({prog_input_three, prog_input_two, prog_input_one}),
    .dout    (di_s)
  );

  // ----------------------------------------------------------------
  // start sequencer
  // ----------------------------------------------------------------
  mhc_start_seq #(
    .GAP_CYC (GAP_CYC)
  ) u_seq (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .start   (start_q),
    .stop    (stop_q),
    .stopped (stopped),
    .run_q   (run),
    .go_q    (go),
    .state   (seq_state)
  );

  assign motor_run         = run;
  assign motor_start_pulse = go;
  assign starter_topology  = topo_q;
  assign phase_order       = phase_q;
  assign rated_pf          = pf_q;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  wire acc     = psel && penable;
  wire wr      = acc && pwrite;
  wire locked  = (level_q != `MHC_LEVEL_OFF);
  wire a_ctrl  = (paddr == `MHC_OFS_CTRL);
  wire a_level = (paddr == `MHC_OFS_LEVEL);
  wire a_topo  = (paddr == `MHC_OFS_TOPO);
  wire a_dicfg = (paddr == `MHC_OFS_DICFG);
  wire a_phase = (paddr == `MHC_OFS_PHASE);
  wire a_pf    = (paddr == `MHC_OFS_PF);
  wire a_stat  = (paddr == `MHC_OFS_STATUS);
  wire a_cfg   = a_topo || a_dicfg || a_phase || a_pf;
  wire mapped  = a_ctrl || a_level || a_cfg || a_stat;

  reg bad_val;
  always @* begin
    bad_val = 1'b0;
    if (a_level) begin
      bad_val = (pwdata[31:5] != 27'h0) || !lvl_ok(pwdata[4:0]);
    end else if (a_topo) begin
      bad_val = (pwdata[31:3] != 29'h0) || !topo_ok(pwdata[2:0]);
    end else if (a_dicfg) begin
      bad_val = (pwdata[31:6] != 26'h0);
    end else if (a_phase) begin
      bad_val = (pwdata[31:2] != 30'h0);
    end else if (a_pf) begin
      bad_val = (pwdata[31:8] != 24'h0) || !pf_ok(pwdata[7:0]);
    end else if (a_stat) begin
      bad_val = 1'b1;
    end
  end

  wire refuse = !mapped || (pwrite && (bad_val || (a_cfg && locked)));
  wire wr_ok  = wr && !refuse;

  assign pready  = 1'b1;
  assign pslverr = acc && refuse;

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hdis_q  <= 1'b0;
      level_q <= `MHC_LEVEL_OFF;
      topo_q  <= `MHC_TOPO_NORMAL;
      dicfg_q <= 6'h00;
      phase_q <= `MHC_PH_INSENS;
      pf_q    <= `MHC_PF_RESET;
      start_q <= 1'b0;
      stop_q  <= 1'b0;
    end else if (ce) begin
      start_q <= wr_ok && a_ctrl && pwdata[`MHC_CTRL_START];
      stop_q  <= wr_ok && a_ctrl && pwdata[`MHC_CTRL_STOP];
      if (wr_ok && a_ctrl) begin
        hdis_q <= pwdata[`MHC_CTRL_HDIS];
      end
      if (wr_ok && a_level) begin
        level_q <= pwdata[4:0];
      end
      if (wr_ok && a_topo) begin
        topo_q <= pwdata[2:0];
      end
      if (wr_ok && a_dicfg) begin
        dicfg_q <= pwdata[5:0];
      end
      if (wr_ok && a_phase) begin
        phase_q <= pwdata[1:0];
      end
      if (wr_ok && a_pf) begin
        pf_q <= pwdata[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // heating decision
  // ----------------------------------------------------------------
  wire [2:0] en_map  = di_has(dicfg_q, `MHC_DI_HEAT_EN);
  wire [2:0] dis_map = di_has(dicfg_q, `MHC_DI_HEAT_DIS);
  wire       any_en  = |en_map;
  wire       any_dis = |dis_map;
  wire       single  = (phase_q == `MHC_PH_SINGLE);

  wire en_gate  = !any_en || |(en_map & di_s);
  wire dis_gate = !any_dis || !(|(dis_map & di_s));

  // stopped covers no-gate case and keeps heat out of gap and run
  wire heat_d = locked && stopped && en_gate && dis_gate
                && !hdis_q
                && !single;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dc_heat_en    <= 1'b0;
      dc_heat_level <= `MHC_LEVEL_OFF;
    end else if (ce) begin
      dc_heat_en    <= heat_d;
      dc_heat_level <= heat_d ? level_q : `MHC_LEVEL_OFF;
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  reg [31:0] rd_d;
  always @* begin
    rd_d = 32'h0000_0000;
    if (a_ctrl) begin
      rd_d[`MHC_CTRL_HDIS] = hdis_q;
    end else if (a_level) begin
      rd_d[4:0] = level_q;
    end else if (a_topo) begin
      rd_d[2:0] = topo_q;
    end else if (a_dicfg) begin
      rd_d[5:0] = dicfg_q;
    end else if (a_phase) begin
      rd_d[1:0] = phase_q;
    end else if (a_pf) begin
      rd_d[7:0] = pf_q;
    end else if (a_stat) begin
      rd_d[0]   = dc_heat_en;
      rd_d[1]   = stopped;
      rd_d[2]   = run;
      rd_d[3]   = locked;
      rd_d[6:4] = di_s;
      rd_d[9:8] = seq_state;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (ce && psel && !penable && !pwrite) begin
      prdata <= rd_d;
    end
  end

endmodule // mhc_top

// >>> sim/mhc_stage_model.sv
// power stage and operator pin model for the heater bench
// assumes pin levels are commanded by the bench
`timescale 1ns/100ps
module mhc_stage_model (
  input  logic       pclk,
  input  logic       presetn,
  input  logic [2:0] pin_req,
  input  logic       dc_heat_en,
  input  logic [4:0] dc_heat_level,
  output logic       pin_one,
  output logic       pin_two,
  output logic       pin_three,
  output logic [4:0] dc_current
);
  assign pin_one   = pin_req[0];
  assign pin_two   = pin_req[1];
  assign pin_three = pin_req[2];
  // dc flows from one cycle after heating is commanded until one cycle after it ends
  always @(posedge pclk or negedge presetn)
    if (!presetn) dc_current <= 5'h00;
    else dc_current <= dc_heat_en ? dc_heat_level : 5'h00;
endmodule // mhc_stage_model

// >>> sim/mhc_top_monitor.sv
// port checker for the heater enable control
// assumes bind onto mhc_top
`timescale 1ns/100ps
module mhc_top_monitor #(
  parameter GAP_CYC = 2
) (
  input logic        pclk,
  input logic        presetn,
  input logic        ce,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [7:0]  paddr,
  input logic [31:0] pwdata,
  input logic        pslverr,
  input logic        dc_heat_en,
  input logic [4:0]  dc_heat_level,
  input logic [2:0]  starter_topology,
  input logic [1:0]  phase_order,
  input logic [7:0]  rated_pf,
  input logic        motor_run,
  input logic        motor_start_pulse
);
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic hdis_q;
  always @(posedge pclk or negedge presetn)
    if (!presetn) hdis_q <= 1'b0;
    else if (ce && psel && penable && pwrite && paddr == 8'h00 && !pslverr) hdis_q <= pwdata[0];
  sequence s_run_begin; $rose(motor_run); endsequence
  sequence s_refused_wr; ce && psel && penable && pwrite && pslverr; endsequence
  chk_level_in_range: assert property (dc_heat_en |-> dc_heat_level != 5'h00 &&
    dc_heat_level <= 5'h19) else $error("heat level out of range");
  chk_level_idle_zero: assert property (!dc_heat_en |-> dc_heat_level == 5'h00)
    else $error("heat level without heating");
  chk_no_heat_run: assert property (motor_run |-> !dc_heat_en)
    else $error("heating while running");
  chk_run_begin_clean: assert property (s_run_begin |-> motor_start_pulse &&
    $past(!dc_heat_en)) else $error("run began badly");
  chk_single_phase_off: assert property ((phase_order == 2'h3 &&
    $past(phase_order) == 2'h3) |-> !dc_heat_en) else $error("heat in single phase");
  chk_hdis_blocks: assert property (hdis_q && $past(hdis_q) |-> !dc_heat_en)
    else $error("heat while disabled");
  chk_topo_legal: assert property (starter_topology <= 3'h5)
    else $error("bad topology");
  chk_refused_stable: assert property (s_refused_wr |=> $stable(starter_topology) &&
    $stable(phase_order) && $stable(rated_pf)) else $error("refused write changed state");
  chk_pf_legal: assert property (rated_pf != 8'h00 && $signed(rated_pf) >= -8'sd100 &&
    $signed(rated_pf) <= 8'sd100) else $error("bad power factor");
endmodule // mhc_top_monitor
bind mhc_top mhc_top_monitor #(.GAP_CYC(GAP_CYC)) u_mon (.pclk(pclk), .presetn(presetn),
  .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pslverr(pslverr), .dc_heat_en(dc_heat_en), .dc_heat_level(dc_heat_level),
  .starter_topology(starter_topology), .phase_order(phase_order), .rated_pf(rated_pf),
  .motor_run(motor_run), .motor_start_pulse(motor_start_pulse));

// >>> sim/test_motor_heater_enable_control.sv
// self-checking bench for the heater enable control
// assumes apb master here, stage model on the far side
`timescale 1ns/100ps
module test_motor_heater_enable_control;
  logic        pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00, pf;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd_q;
  logic [2:0]  pin_req = 3'h0, topo;
  logic [4:0]  lvl, cur;
  logic [1:0]  ph;
  logic        pready, pslverr, err_q, heat, run, spls, p1, p2, p3;
  int          miscompares = 0, n_tests = 0, k, n_spls = 0;
  always #20 pclk = ~pclk;
  // count start pulses so the one-cycle pulse is not missed
  always @(posedge pclk) if (spls === 1'b1) n_spls++;
  mhc_top #(.GAP_CYC(2)) u_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .prog_input_one(p1), .prog_input_two(p2),
    .prog_input_three(p3), .dc_heat_en(heat), .dc_heat_level(lvl),
    .starter_topology(topo), .phase_order(ph), .rated_pf(pf), .motor_run(run),
    .motor_start_pulse(spls));
  mhc_stage_model u_stage (.pclk(pclk), .presetn(presetn), .pin_req(pin_req),
    .dc_heat_en(heat), .dc_heat_level(lvl), .pin_one(p1), .pin_two(p2), .pin_three(p3),
    .dc_current(cur));
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task settle; repeat (8) @(posedge pclk); endtask
  task run_wait; k = 0; while (run !== 1'b1 && k < 100) begin @(posedge pclk); k++; end endtask
  task conclude;
    $display("tests %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin repeat (5000) @(posedge pclk); miscompares++; conclude; end
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 8'h04, 0); chk("level_rst", rd_q, 0);
    apb(0, 8'h08, 0); chk("topo_rst", rd_q, 0);
    apb(0, 8'h14, 0); chk("pf_rst", rd_q, 32'h0000_00A4);
    apb(1, 8'h14, 0); chk("pf_zero", 32'(err_q), 1);
    apb(1, 8'h14, 32'h0000_0065); chk("pf_high", 32'(err_q), 1);
    apb(1, 8'h14, 32'h0000_009C); apb(0, 8'h14, 0); chk("pf_min", rd_q, 32'h0000_009C);
    chk("pf_pin", 32'(pf), 32'h0000_009C);
    for (k = 0; k < 6; k++) begin
      apb(1, 8'h08, k); apb(0, 8'h08, 0); chk("topo_rd", rd_q, 32'(k));
      chk("topo_pin", 32'(topo), 32'(k));
    end
    apb(1, 8'h08, 6); chk("topo_bad", 32'(err_q), 1);
    apb(1, 8'h08, 0);
    apb(1, 8'h04, 26); chk("level_26", 32'(err_q), 1);
    apb(1, 8'h04, 25); settle; chk("heat_free", 32'(heat), 1);
    chk("heat_lvl", 32'(lvl), 25); chk("dc_cur", 32'(cur), 25);
    apb(1, 8'h08, 1); chk("lock_topo", 32'(err_q), 1);
    apb(1, 8'h10, 3); chk("lock_phase", 32'(err_q), 1);
    chk("phase_pin", 32'(ph), 0);
    apb(0, 8'h18, 0); chk("locked", 32'(rd_q[3]), 1);
    apb(1, 8'h00, 1); settle; chk("hdis_on", 32'(heat), 0);
    apb(1, 8'h00, 0); settle; chk("hdis_off", 32'(heat), 1);
    apb(1, 8'h00, 2); run_wait; chk("run", 32'(run), 1); chk("heat_run", 32'(heat), 0);
    settle; chk("start_pls", 32'(n_spls), 1);
    apb(1, 8'h00, 4); settle; chk("heat_stop", 32'(heat), 1);
    apb(1, 8'h04, 0); apb(1, 8'h10, 3); apb(1, 8'h04, 5);
    settle; chk("single_ph", 32'(heat), 0);
    apb(1, 8'h04, 0); apb(1, 8'h10, 0); apb(1, 8'h0C, 1); apb(1, 8'h04, 5);
    settle; chk("en_low", 32'(heat), 0);
    pin_req <= 3'h1; settle; chk("en_high", 32'(heat), 1); chk("lvl5", 32'(lvl), 5);
    apb(1, 8'h00, 2); run_wait; settle; chk("en_run", 32'(heat), 0);
    chk("start_pls2", 32'(n_spls), 2);
    apb(1, 8'h00, 4); apb(1, 8'h04, 0); apb(1, 8'h0C, 8); pin_req <= 3'h2;
    apb(1, 8'h04, 7); settle; chk("dis_high", 32'(heat), 0);
    pin_req <= 3'h0; settle; chk("dis_low", 32'(heat), 1);
    apb(0, 8'h1C, 0); chk("unmapped", 32'(err_q), 1);
    conclude;
  end
endmodule // test_motor_heater_enable_control
